// >>> dual_timer_ctrl_capture.sv
/*
 * Control, synchronisation and high-phase capture registers of a paired
 * 8-bit / 16-bit counter/timer, with interrupt status and pin select.
 * Assumes a single clock, an 8-bit register port driven on clk_i, and
 * reload values supplied by load registers kept elsewhere.
 */
// Our own choice: strobed register access.
`timescale 1ns/1ps
module dual_timer_ctrl_capture (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic [dual_timer_pkg::ADDR_W-1:0] addr_i,
    input wire logic [dual_timer_pkg::DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [dual_timer_pkg::T8_W-1:0] reload8_i,
    input wire logic [dual_timer_pkg::T16_W-1:0] reload16_i,
    input wire logic demod_i,
    input wire logic gpio_out_i,
    input wire logic gpio_oe_i,
    output logic [dual_timer_pkg::DATA_W-1:0] rdata_o,
    output logic pin_o,
    output logic pin_oe_o,
    output logic irq_o
);
    import dual_timer_pkg::*;

    logic t8_en;
    logic t16_en;
    logic sync_mode;
    logic single;
    logic tout;
    clk_sel_t clk_sel;
    logic capmask;
    logic tomask;
    logic pinsel;
    logic [CAP_W-1:0] hicap;
    logic [CAP_W-1:0] high_cnt;
    logic [NUM_EV-1:0] status;
    logic [NUM_EV-1:0] irq_en;
    logic [PSC_W-1:0] psc;
    logic t8_out;
    logic demod_meta;
    logic demod_s;
    logic demod_d;

    timer_if #(.W(T8_W)) t8_if();
    timer_if #(.W(T16_W)) t16_if();

    reload_counter u_t8 (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .tif(t8_if.cnt)
    );
    reload_counter u_t16 (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .tif(t16_if.cnt)
    );

    // address decode
    wire wr_ctrl = wr_i && (addr_i == OFF_CTRL);
    wire wr_sync = wr_i && (addr_i == OFF_SYNC);
    wire wr_clr = wr_i && (addr_i == OFF_IRQ_CLEAR);
    wire wr_ien = wr_i && (addr_i == OFF_IRQ_ENABLE);

    wire en8_wr = wr_ctrl || wr_sync;
    wire en8_val = wr_ctrl ? wdata_i[CTRL_EN] : wdata_i[SYNC_EN8];
    wire start8 = en8_wr && en8_val && !t8_en;
    wire start16 = wr_sync && wdata_i[SYNC_EN16] && !t16_en;
    wire exp8 = t8_if.expire;
    wire exp16 = t16_if.expire;

    logic [PSC_W-1:0] psc_mask;
    always_comb
    begin
        unique case (clk_sel)
            CLK_DIV1: psc_mask = PSC_MASK1;
            CLK_DIV2: psc_mask = PSC_MASK2;
            CLK_DIV4: psc_mask = PSC_MASK4;
            CLK_DIV8: psc_mask = PSC_MASK8;
        endcase
    end
    wire tick8 = ((psc & psc_mask) == psc_mask);

    assign t8_if.tick = tick8;
    assign t8_if.run = t8_en;
    assign t8_if.reload = reload8_i;
    assign t16_if.run = t16_en;
    assign t16_if.reload = reload16_i;
    assign t8_if.restart = start8 || (sync_mode && start16);
    assign t16_if.restart = start16 || (sync_mode && start8);
    assign t16_if.tick = sync_mode ? tick8 : 1'b1;

    // capture edge: reads only the second sync stage onward
    wire demod_fall = demod_d && !demod_s;
    wire cap_full = (high_cnt == {CAP_W{1'b1}});

    wire [NUM_EV-1:0] ev = {demod_fall, exp16, exp8};
    wire [NUM_EV-1:0] clr = wr_clr ? wdata_i[NUM_EV-1:0] : '0;
    // masks for the 8-bit and capture sources on top of enable register
    wire [NUM_EV-1:0] src_mask = {capmask, 1'b1, tomask};
    wire [NUM_EV-1:0] irq_src = status & irq_en & src_mask;

    wire [DATA_W-1:0] ctrl_rd = {t8_en, single, tout, clk_sel,
                                 capmask, tomask, pinsel};
    wire [DATA_W-1:0] sync_rd = {t16_en, t8_en, sync_mode, SYNC_RSV_READ};
    wire [DATA_W-1:0] stat_rd = {{(DATA_W-NUM_EV){1'b0}}, status};
    wire [DATA_W-1:0] ien_rd = {{(DATA_W-NUM_EV){1'b0}}, irq_en};
    wire [DATA_W-1:0] next_rdata =
        (addr_i == OFF_CTRL) ? ctrl_rd :
        (addr_i == OFF_SYNC) ? sync_rd :
        (addr_i == OFF_HICAP) ? hicap :
        (addr_i == OFF_IRQ_STATUS) ? stat_rd :
        (addr_i == OFF_IRQ_ENABLE) ? ien_rd : READ_IDLE;

    // enable: software write, single pass stop
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            t8_en <= 1'b0;
        else if (ce_i)
        begin
            if (en8_wr)
                t8_en <= en8_val;
            else if (exp8 && single)
                t8_en <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            t16_en <= 1'b0;
            sync_mode <= 1'b0;
        end
        else if (ce_i && wr_sync)
        begin
            t16_en <= wdata_i[SYNC_EN16];
            sync_mode <= wdata_i[SYNC_MODE];
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            single <= CTRL_RST[CTRL_SINGLE];
            clk_sel <= clk_sel_t'(CTRL_RST[CTRL_CLK_HI:CTRL_CLK_LO]);
            capmask <= CTRL_RST[CTRL_CAPMASK];
            tomask <= CTRL_RST[CTRL_TOMASK];
            pinsel <= CTRL_RST[CTRL_PINSEL];
            irq_en <= '0;
        end
        else if (ce_i)
        begin
            if (wr_ctrl)
            begin
                single <= wdata_i[CTRL_SINGLE];
                clk_sel <= clk_sel_t'(wdata_i[CTRL_CLK_HI:CTRL_CLK_LO]);
                capmask <= wdata_i[CTRL_CAPMASK];
                tomask <= wdata_i[CTRL_TOMASK];
                pinsel <= wdata_i[CTRL_PINSEL];
            end
            if (wr_ien)
                irq_en <= wdata_i[NUM_EV-1:0];
        end
    end

    // time-out flag and sticky status: a new event beats a clear
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            tout <= 1'b0;
            status <= '0;
        end
        else if (ce_i)
        begin
            tout <= exp8 || (tout && !(wr_ctrl && wdata_i[CTRL_TOUT]));
            status <= ev | (status & ~clr);
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            psc <= '0;
            t8_out <= 1'b0;
            demod_meta <= 1'b0;
            demod_s <= 1'b0;
            demod_d <= 1'b0;
        end
        else if (ce_i)
        begin
            psc <= psc + 1'b1;
            t8_out <= t8_out ^ exp8;
            demod_meta <= demod_i;
            demod_s <= demod_meta;
            demod_d <= demod_s;
        end
    end

    // count ticks while input high and the 8-bit timer is enabled, saturate
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            high_cnt <= '0;
            hicap <= HICAP_RST;
        end
        else if (ce_i)
        begin
            if (demod_fall)
            begin
                high_cnt <= '0;
                hicap <= high_cnt;
            end
            else if (demod_s && t8_en && tick8 && !cap_full)
                high_cnt <= high_cnt + 1'b1;
        end
    end

    // outputs registered; read data only in the cycle after rd_i
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rdata_o <= READ_IDLE;
            pin_o <= 1'b0;
            pin_oe_o <= 1'b0;
            irq_o <= 1'b0;
        end
        else if (ce_i)
        begin
            rdata_o <= rd_i ? next_rdata : READ_IDLE;
            pin_o <= pinsel ? t8_out : gpio_out_i;
            pin_oe_o <= pinsel || gpio_oe_i;
            irq_o <= |irq_src;
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    a_enable_write: assert property (
        ce_i && wr_ctrl |=> t8_en == $past(wdata_i[CTRL_EN]))
        else $error("8-bit enable did not follow write");
    a_sync_enables: assert property (
        ce_i && wr_sync |=> t16_en == $past(wdata_i[SYNC_EN16])
            && t8_en == $past(wdata_i[SYNC_EN8]))
        else $error("sync register enables wrong");
    a_sync_start: assert property (
        ce_i && sync_mode && start8 |=> t16_if.count == $past(reload16_i))
        else $error("16-bit counter not restarted in sync mode");
    a_timeout_mask: assert property (
        ce_i && !tomask && !(status[EV_T16] && irq_en[EV_T16])
            && !(status[EV_CAP] && irq_en[EV_CAP] && capmask) |=> !irq_o)
        else $error("masked time-out raised interrupt");
    a_pin_select: assert property (
        ce_i && pinsel |=> pin_oe_o && pin_o == $past(t8_out))
        else $error("pin not driven by 8-bit timer output");
    a_capture_ro: assert property (
        ce_i && wr_i && addr_i == OFF_HICAP && !demod_fall |=> $stable(hicap))
        else $error("write changed capture register");
    a_capture_high: assert property (
        ce_i && demod_fall |=> hicap == $past(high_cnt))
        else $error("capture missed high count");
    a_reserved_ones: assert property (
        ce_i && rd_i && addr_i == OFF_SYNC |=> rdata_o[4:0] == SYNC_RSV_READ)
        else $error("reserved sync bits not ones");
    a_div8_tick: assert property (
        ce_i && clk_sel == CLK_DIV8 && tick8 && !wr_ctrl |=> !tick8)
        else $error("divide by 8 ticks too close");
    a_start_reload: assert property (
        ce_i && start8 |=> t8_if.count == $past(reload8_i))
        else $error("8-bit counter not loaded on start");

    c_t8_expire: cover property (ce_i && exp8);
    c_capture: cover property (ce_i && demod_fall && high_cnt != '0);
    c_irq: cover property (irq_o);
    c_sync_run: cover property (sync_mode && t8_en && t16_en);
endmodule

// >>> dual_timer_pkg.sv
/*
 * Shared constants for the dual timer control and capture block:
 * register offsets, field positions, reset values and prescale codes.
 * Assumes an 8-bit register port with a 4-bit register address.
 */
package dual_timer_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int CAP_W = 8;
    localparam int T8_W = 8;
    localparam int T16_W = 16;
    localparam int PSC_W = 3;

    // register offsets
    localparam logic [3:0] OFF_CTRL = 4'h0;
    localparam logic [3:0] OFF_SYNC = 4'h3;
    localparam logic [3:0] OFF_HICAP = 4'hB;
    localparam logic [3:0] OFF_IRQ_STATUS = 4'hC;
    localparam logic [3:0] OFF_IRQ_CLEAR = 4'hD;
    localparam logic [3:0] OFF_IRQ_ENABLE = 4'hE;

    // eight_bit_timer_control fields
    localparam int CTRL_EN = 7;
    localparam int CTRL_SINGLE = 6;
    localparam int CTRL_TOUT = 5;
    localparam int CTRL_CLK_HI = 4;
    localparam int CTRL_CLK_LO = 3;
    localparam int CTRL_CAPMASK = 2;
    localparam int CTRL_TOMASK = 1;
    localparam int CTRL_PINSEL = 0;

    // timer_sync_control fields
    localparam int SYNC_EN16 = 7;
    localparam int SYNC_EN8 = 6;
    localparam int SYNC_MODE = 5;
    localparam logic [4:0] SYNC_RSV_READ = 5'h1F;

    // reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] HICAP_RST = 8'h00;
    localparam logic [7:0] READ_IDLE = 8'h00;

    // interrupt event bits
    localparam int EV_T8 = 0;
    localparam int EV_T16 = 1;
    localparam int EV_CAP = 2;
    localparam int NUM_EV = 3;

    typedef enum logic [1:0] {
        CLK_DIV1 = 2'h0,
        CLK_DIV2 = 2'h1,
        CLK_DIV4 = 2'h2,
        CLK_DIV8 = 2'h3
    } clk_sel_t;

    localparam logic [2:0] PSC_MASK1 = 3'h0;
    localparam logic [2:0] PSC_MASK2 = 3'h1;
    localparam logic [2:0] PSC_MASK4 = 3'h3;
    localparam logic [2:0] PSC_MASK8 = 3'h7;
endpackage

// >>> timer_if.sv
/*
 * Control and result signals between the timer controller and one
 * reload counter. Assumes both ends share clk_i.
 */
`timescale 1ns/1ps
interface timer_if #(parameter int W = 8);
    logic tick;
    logic restart;
    logic run;
    logic [W-1:0] reload;
    logic expire;
    logic [W-1:0] count;
    modport ctrl(output tick, output restart, output run, output reload,
                 input expire, input count);
    modport cnt(input tick, input restart, input run, input reload,
                output expire, output count);
endinterface

// >>> reload_counter.sv
/*
 * Down counter with reload and a one-cycle expiry pulse, used for both
 * timers. Assumes tick, run and restart come from logic on clk_i.
 */
`timescale 1ns/1ps
module reload_counter (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    timer_if.cnt tif
);
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            tif.count <= '0;
            tif.expire <= 1'b0;
        end
        else if (ce_i)
        begin
            tif.expire <= 1'b0;
            if (tif.restart)
                tif.count <= tif.reload;
            else if (tif.run && tif.tick)
            begin
                // expiry reloads, so modulo-n needs no extra step
                if (tif.count == '0)
                begin
                    tif.count <= tif.reload;
                    tif.expire <= 1'b1;
                end
                else
                    tif.count <= tif.count - 1'b1;
            end
        end
    end
endmodule

// >>> tb_dual_timer_ctrl_capture.sv
/*
 * Self-checking bench for the dual timer control and capture block.
 * Assumes the package and the design files are compiled first.
 */
`timescale 1ns/1ps
`define check(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
    err_count++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module tb_dual_timer_ctrl_capture;
    import dual_timer_pkg::*;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic ce_i = 1'b1;
    logic [ADDR_W-1:0] addr_i = 4'h0;
    logic [DATA_W-1:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [T8_W-1:0] reload8_i = 8'h03;
    logic [T16_W-1:0] reload16_i = 16'h0005;
    logic demod_i = 1'b0;
    logic gpio_out_i = 1'b1;
    logic gpio_oe_i = 1'b0;
    logic [DATA_W-1:0] rdata_o;
    logic pin_o;
    logic pin_oe_o;
    logic irq_o;
    int err_count = 0;
    int comparisons = 0;
    int cycles = 0;
    logic [7:0] rd;

    dual_timer_ctrl_capture dut (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .reload8_i(reload8_i), .reload16_i(reload16_i),
        .demod_i(demod_i), .gpio_out_i(gpio_out_i),
        .gpio_oe_i(gpio_oe_i), .rdata_o(rdata_o), .pin_o(pin_o),
        .pin_oe_o(pin_oe_o), .irq_o(irq_o)
    );

    always #20 clk_i = ~clk_i;

    // hang guard, generous for the whole sequence
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_count++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        if (err_count == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask

    task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // cycles between two pin toggles, second interval taken
    task automatic toggle_gap(output int g);
        logic last;
        g = 0;
        repeat (2)
        begin
            last = pin_o;
            g = 0;
            while (pin_o === last && g < 500)
            begin
                @(posedge clk_i);
                #1 g++;
            end
        end
    endtask

    task automatic t_reset_values();
        reg_rd(OFF_CTRL, rd);
        `check("ctrl reset", 8'h00, rd)
        reg_rd(OFF_SYNC, rd);
        `check("sync reset", 8'h1F, rd)
        reg_rd(OFF_HICAP, rd);
        `check("hicap reset", 8'h00, rd)
    endtask

    task automatic t_enables();
        reg_wr(OFF_CTRL, 8'h80);
        reg_rd(OFF_CTRL, rd);
        `check("ctrl enable", 1'b1, rd[7])
        reg_rd(OFF_SYNC, rd);
        `check("sync t8 en", 8'h5F, rd)
        reg_wr(OFF_SYNC, 8'h80);
        reg_rd(OFF_CTRL, rd);
        `check("ctrl stopped", 1'b0, rd[7])
        reg_wr(OFF_SYNC, 8'h3F);
        reg_rd(OFF_SYNC, rd);
        `check("sync mode", 8'h3F, rd)
        reg_wr(OFF_SYNC, 8'h00);
        reg_rd(OFF_SYNC, rd);
        `check("sync cleared", 8'h1F, rd)
    endtask

    task automatic t_single_pass();
        reg_wr(OFF_CTRL, 8'hC0);
        idle(30);
        reg_rd(OFF_CTRL, rd);
        `check("single pass stop", 8'h60, rd)
        reg_wr(OFF_CTRL, 8'h20);
        reg_rd(OFF_CTRL, rd);
        `check("timeout cleared", 8'h00, rd)
    endtask

    task automatic t_irq_mask();
        reg_wr(OFF_IRQ_CLEAR, 8'h07);
        reg_wr(OFF_IRQ_ENABLE, 8'h01);
        reg_wr(OFF_CTRL, 8'h80);
        idle(30);
        #1;
        `check("irq masked", 1'b0, irq_o)
        reg_wr(OFF_CTRL, 8'h02);
        idle(2);
        #1;
        `check("irq unmasked", 1'b1, irq_o)
        reg_wr(OFF_IRQ_CLEAR, 8'h01);
        idle(2);
        #1;
        `check("irq cleared", 1'b0, irq_o)
        reg_wr(OFF_IRQ_ENABLE, 8'h00);
    endtask

    task automatic t_pin_select();
        idle(2);
        #1;
        `check("pin gpio oe", 1'b0, pin_oe_o)
        `check("pin gpio val", 1'b1, pin_o)
        reg_wr(OFF_CTRL, 8'h01);
        idle(2);
        #1;
        `check("pin timer oe", 1'b1, pin_oe_o)
    endtask

    task automatic t_prescale();
        int base;
        int g;
        reg_wr(OFF_CTRL, 8'h81);
        toggle_gap(base);
        for (int s = 1; s < 4; s++)
        begin
            reg_wr(OFF_CTRL, 8'h81 | 8'(s << 3));
            toggle_gap(g);
            // divide by 2, 4, 8 stretches the toggle gap
            `check("prescale gap", base << s, g)
        end
        reg_wr(OFF_CTRL, 8'h00);
    endtask

    task automatic t_capture();
        reg_wr(OFF_HICAP, 8'h5A);
        reg_rd(OFF_HICAP, rd);
        `check("hicap write", 8'h00, rd)
        reg_rd(4'h7, rd);
        `check("unmapped read", 8'h00, rd)
        reg_wr(OFF_IRQ_CLEAR, 8'h07);
        reg_wr(OFF_CTRL, 8'h80);
        @(posedge clk_i);
        demod_i <= 1'b1;
        idle(10);
        demod_i <= 1'b0;
        idle(6);
        reg_rd(OFF_HICAP, rd);
        // one tick per clock at divide by 1
        `check("hicap count", 8'd10, rd)
        reg_rd(OFF_IRQ_STATUS, rd);
        `check("capture status", 1'b1, rd[EV_CAP])
        reg_wr(OFF_CTRL, 8'h00);
    endtask

    // clock enable low must hold the toggling pin and drop writes
    task automatic t_freeze();
        logic held;
        reg_wr(OFF_CTRL, 8'h81);
        @(posedge clk_i);
        ce_i <= 1'b0;
        #1 held = pin_o;
        idle(12);
        #1;
        `check("frozen pin", held, pin_o)
        reg_wr(OFF_CTRL, 8'h00);
        ce_i <= 1'b1;
        reg_rd(OFF_CTRL, rd);
        `check("frozen write", 1'b1, rd[CTRL_EN])
        reg_wr(OFF_CTRL, 8'h00);
    endtask

    task automatic t_sync_mode();
        reg_wr(OFF_CTRL, 8'h18);
        reg_wr(OFF_IRQ_CLEAR, 8'h07);
        reg_wr(OFF_SYNC, 8'h20);
        reg_wr(OFF_SYNC, 8'hE0);
        idle(20);
        reg_rd(OFF_IRQ_STATUS, rd);
        // shared divide-by-8 tick keeps the 16-bit count slow
        `check("sync t16 early", 1'b0, rd[EV_T16])
        idle(50);
        reg_rd(OFF_IRQ_STATUS, rd);
        `check("sync t16 late", 1'b1, rd[EV_T16])
        reg_wr(OFF_SYNC, 8'h00);
        reg_wr(OFF_IRQ_CLEAR, 8'h07);
        reg_wr(OFF_SYNC, 8'h80);
        idle(10);
        reg_rd(OFF_IRQ_STATUS, rd);
        `check("free t16", 1'b1, rd[EV_T16])
        reg_wr(OFF_SYNC, 8'h00);
        reg_wr(OFF_CTRL, 8'h00);
    endtask

    initial
    begin
        repeat (16) @(posedge clk_i);
        rst_n_i <= 1'b1;
        t_reset_values();
        t_enables();
        t_single_pass();
        t_irq_mask();
        t_pin_select();
        t_prescale();
        t_freeze();
        t_capture();
        t_sync_mode();
        tally_and_finish();
    end
endmodule
